// File: wdg_pkg.sv
/*
  Constants, bus carrier and key detector states for the one-time-enable watchdog.
  Assumes the core clock is the machine cycle and that the special function register
  write and read strobes arrive on that same clock.
*/
`default_nettype none

package wdg_pkg;

  // Special function register addresses.
  localparam logic [7:0] RESTART_ADDR = 8'ha6;
  localparam logic [7:0] AUX_ADDR = 8'h8e;

  // Two-byte arming and service key.
  localparam logic [7:0] KEY_FIRST = 8'h1e;
  localparam logic [7:0] KEY_SECOND = 8'he1;

  // Field position of the idle halt control bit in the auxiliary control register.
  localparam int IDLE_HALT_BIT = 4;
  localparam logic IDLE_HALT_RESET = 1'b0;

  // Counter geometry and the value at which it overflows.
  localparam int CNT_WIDTH = 14;
  localparam int OVERFLOW_COUNT = 16383;

  // Reset-out pulse length, printed in oscillator periods.
  localparam int RST_PULSE_OSC = 98;
  // Oscillator periods per machine cycle, the rate at which clk runs.
  localparam int OSC_PER_MCYC = 12;
  // A least time: round up to whole machine cycles.
  localparam int RST_PULSE_CYC = (RST_PULSE_OSC + OSC_PER_MCYC - 1) / OSC_PER_MCYC;

  // Value read back from the restart register, which holds nothing readable.
  localparam logic [7:0] RESTART_READ_VALUE = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } wdg_sfr_req_s;

  typedef enum logic [0:0] {
    KEY_WAIT_FIRST,
    KEY_WAIT_SECOND
  } wdg_key_e;

endpackage

`default_nettype wire

// File: wdg_one_time_enable.sv
/*
  One-time-enable watchdog: a machine cycle counter armed and serviced by a key
  sequence, with a reset-out pulse on overflow.
  Assumes clk is the machine cycle clock, clk_en low models a stopped oscillator,
  and idle_mode and power_down come from logic on the same clock.
*/
`default_nettype none

module wdg_one_time_enable #(
  parameter int CNT_W = wdg_pkg::CNT_WIDTH,
  parameter int PULSE_CYC = wdg_pkg::RST_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire wdg_pkg::wdg_sfr_req_s sfr_req,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic wake_int_n,
  output logic [7:0] sfr_rdata,
  output logic wdt_armed,
  output logic wdt_reset,
  output logic rst_pin_o,
  output logic rst_pin_oe_n
);

  localparam int PW = $clog2(PULSE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(wdg_pkg::OVERFLOW_COUNT);
  localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYC - 1);

  generate
    if (CNT_W < 2 || wdg_pkg::OVERFLOW_COUNT >= (2 ** CNT_W))
    begin : g_bad_width
      $error("Counter width cannot hold the overflow count.");
    end
    if (PULSE_CYC < 1)
    begin : g_bad_pulse
      $error("Reset-out pulse must last at least one cycle.");
    end
  endgenerate

  logic wake_meta_q;
  logic wake_sync_q;
  logic pd_q;
  logic wake_hold_q;
  wdg_pkg::wdg_key_e key_q;
  logic armed_q;
  logic [CNT_W-1:0] cnt_q;
  logic idle_halt_q;
  logic drive_q;
  logic [PW-1:0] pulse_cnt_q;
  logic [7:0] rdata_q;

  logic restart_wr;
  logic aux_wr;
  logic key_done;
  logic run;
  logic overflow;

  assign restart_wr = sfr_req.wr && (sfr_req.addr == wdg_pkg::RESTART_ADDR);
  assign aux_wr = sfr_req.wr && (sfr_req.addr == wdg_pkg::AUX_ADDR);

  assign key_done = restart_wr && (key_q == wdg_pkg::KEY_WAIT_SECOND) &&
                    (sfr_req.data == wdg_pkg::KEY_SECOND);

  // The counter only advances while the oscillator runs, the wake hold is clear
  // and idle does not freeze it.
  assign run = armed_q && !power_down && !wake_hold_q && !(idle_mode && idle_halt_q);

  // A service landing in the overflow cycle wins, so a just-in-time write is honoured.
  assign overflow = run && (cnt_q == CNT_MAX) && !key_done;

  // The wake pin comes from outside, so it is synchronised before anything looks at it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_meta_q <= 1'b1;
      wake_sync_q <= 1'b1;
    end
    else if (clk_en)
    begin
      wake_meta_q <= wake_int_n;
      wake_sync_q <= wake_meta_q;
    end
  end

  // Leaving power-down with the wake pin still low starts a hold that lasts until the
  // pin returns high; the handler then runs before the count can resume.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_q <= 1'b0;
      wake_hold_q <= 1'b0;
    end
    else if (clk_en)
    begin
      pd_q <= power_down;
      if (pd_q && !power_down && !wake_sync_q)
      begin
        wake_hold_q <= 1'b1;
      end
      else if (wake_sync_q)
      begin
        wake_hold_q <= 1'b0;
      end
    end
  end

  // Key detector: a repeated first key keeps waiting for the second; any other unexpected restart write starts over.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_q <= wdg_pkg::KEY_WAIT_FIRST;
    end
    else if (clk_en && restart_wr)
    begin
      case (key_q)
        wdg_pkg::KEY_WAIT_FIRST:
        begin
          if (sfr_req.data == wdg_pkg::KEY_FIRST)
          begin
            key_q <= wdg_pkg::KEY_WAIT_SECOND;
          end
        end
        wdg_pkg::KEY_WAIT_SECOND:
        begin
          if (sfr_req.data == wdg_pkg::KEY_FIRST)
          begin
            key_q <= wdg_pkg::KEY_WAIT_SECOND;
          end
          else
          begin
            key_q <= wdg_pkg::KEY_WAIT_FIRST;
          end
        end
        default:
        begin
          key_q <= wdg_pkg::KEY_WAIT_FIRST;
        end
      endcase
    end
  end

  // Arming is one way: no register write can clear it, only reset or overflow.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (overflow)
      begin
        armed_q <= 1'b0;
      end
      else if (key_done)
      begin
        armed_q <= 1'b1;
      end
    end
  end

  // The counter has no read or write path; software only clears it with the key.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (overflow || key_done)
      begin
        cnt_q <= '0;
      end
      else if (run)
      begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // Idle halt control bit, the only bit of the auxiliary control register held here.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_halt_q <= wdg_pkg::IDLE_HALT_RESET;
    end
    else if (clk_en && aux_wr)
    begin
      idle_halt_q <= sfr_req.data[wdg_pkg::IDLE_HALT_BIT];
    end
  end

  // Reset-out pulse; its length is fixed and does not depend on software.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_q <= 1'b0;
      pulse_cnt_q <= '0;
    end
    else if (clk_en)
    begin
      if (overflow)
      begin
        drive_q <= 1'b1;
        pulse_cnt_q <= PULSE_LAST;
      end
      else if (drive_q)
      begin
        if (pulse_cnt_q == '0)
        begin
          drive_q <= 1'b0;
        end
        else
        begin
          pulse_cnt_q <= pulse_cnt_q - PW'(1);
        end
      end
    end
  end

  // Outputs each from their own flop, all following the same pulse timing.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_reset <= 1'b0;
      rst_pin_o <= 1'b0;
      rst_pin_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      if (overflow)
      begin
        wdt_reset <= 1'b1;
        rst_pin_o <= 1'b1;
        rst_pin_oe_n <= 1'b0;
      end
      else if (drive_q && pulse_cnt_q == '0)
      begin
        wdt_reset <= 1'b0;
        rst_pin_o <= 1'b0;
        rst_pin_oe_n <= 1'b1;
      end
    end
  end

  // Armed status mirror for the rest of the device.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_armed <= 1'b0;
    end
    else if (clk_en)
    begin
      if (overflow)
      begin
        wdt_armed <= 1'b0;
      end
      else if (key_done)
      begin
        wdt_armed <= 1'b1;
      end
    end
  end

  // Read port: the restart address returns a constant, never the count.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (clk_en && sfr_req.rd)
    begin
      if (sfr_req.addr == wdg_pkg::AUX_ADDR)
      begin
        rdata_q <= 8'(idle_halt_q) << wdg_pkg::IDLE_HALT_BIT;
      end
      else
      begin
        rdata_q <= wdg_pkg::RESTART_READ_VALUE;
      end
    end
  end

  assign sfr_rdata = rdata_q;

endmodule

`default_nettype wire

// File: wdg_one_time_enable_props.sv
/*
  Port checker for the one-time-enable watchdog.
  Assumes it is bound onto wdg_one_time_enable and sees only its ports.
*/
`default_nettype none
module wdg_one_time_enable_props #(
  parameter int CNT_W = wdg_pkg::CNT_WIDTH,
  parameter int PULSE_CYC = wdg_pkg::RST_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire wdg_pkg::wdg_sfr_req_s sfr_req,
  input wire logic idle_mode,
  input wire logic power_down,
  input wire logic wake_int_n,
  input wire logic [7:0] sfr_rdata,
  input wire logic wdt_armed,
  input wire logic wdt_reset,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n
);
  localparam int MIN_RUN = 16384;
  logic key1;
  logic key2;
  logic rd_key;
  logic [15:0] since_q;
  assign rd_key = clk_en && sfr_req.rd && sfr_req.addr == wdg_pkg::RESTART_ADDR;
  assign key1 = clk_en && sfr_req.wr && sfr_req.addr == wdg_pkg::RESTART_ADDR
    && sfr_req.data == wdg_pkg::KEY_FIRST;
  assign key2 = clk_en && sfr_req.wr && sfr_req.addr == wdg_pkg::RESTART_ADDR
    && sfr_req.data == wdg_pkg::KEY_SECOND;
  // Counts every cycle while armed and clears on any second-key write, so it can understate as well as overstate the run time.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      since_q <= 16'h0000;
    else if (key2 || !wdt_armed)
      since_q <= 16'h0000;
    else
      since_q <= since_q + 16'h0001;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_key;
    key1 ##2 key2;
  endsequence
  sequence s_pulse;
    wdt_reset [*8] ##1 !wdt_reset;
  endsequence
  a_pulse_length: assert property ($rose(wdt_reset) |=> s_pulse)
    else $error("reset pulse length wrong");
  a_pin_follows: assert property (rst_pin_o == wdt_reset && rst_pin_oe_n == !wdt_reset)
    else $error("reset pin not matching request");
  a_trip_disarms: assert property ($rose(wdt_reset) |-> $past(wdt_armed) && !wdt_armed)
    else $error("overflow without armed counter");
  a_key_arms: assert property (s_key |=> wdt_armed)
    else $error("key pair did not arm");
  a_no_disarm: assert property ($fell(wdt_armed) |-> wdt_reset)
    else $error("disarmed without overflow");
  a_arm_cause: assert property ($rose(wdt_armed) |-> $past(key2))
    else $error("armed without second key");
  a_min_run: assert property ($rose(wdt_reset) |-> since_q >= MIN_RUN)
    else $error("overflow came too early");
  a_key_unread: assert property (rd_key |=> sfr_rdata == 8'h00)
    else $error("restart register readable");
  a_pd_no_trip: assert property ($past(power_down) |-> !$rose(wdt_reset))
    else $error("overflow during power-down");
endmodule
bind wdg_one_time_enable wdg_one_time_enable_props #(.CNT_W(CNT_W), .PULSE_CYC(PULSE_CYC))
  u_props (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sfr_req(sfr_req),
  .idle_mode(idle_mode), .power_down(power_down), .wake_int_n(wake_int_n),
  .sfr_rdata(sfr_rdata), .wdt_armed(wdt_armed), .wdt_reset(wdt_reset),
  .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n));
`default_nettype wire

// File: wdg_one_time_enable_tb.sv
/*
  Self-checking bench for the one-time-enable watchdog.
  Assumes the package, design and checker are compiled before it.
*/
`default_nettype none
module wdg_one_time_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] KA = wdg_pkg::RESTART_ADDR;
  logic clk, rst_n, clk_en, idle_mode, power_down, wake_int_n;
  logic armed, wres, pin_o, pin_oe_n;
  logic [7:0] rdata;
  wdg_pkg::wdg_sfr_req_s req;
  int fail_count = 0;
  int num_checks = 0;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
  wdg_one_time_enable dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .sfr_req(req),
    .idle_mode(idle_mode), .power_down(power_down), .wake_int_n(wake_int_n),
    .sfr_rdata(rdata), .wdt_armed(armed), .wdt_reset(wres), .rst_pin_o(pin_o),
    .rst_pin_oe_n(pin_oe_n));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic key();
    wr(KA, wdg_pkg::KEY_FIRST);
    wr(KA, wdg_pkg::KEY_SECOND);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // The tests take about 98.3k cycles, so this only fires on a hang.
  initial
  begin
    #990_000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    idle_mode = 1'b0;
    power_down = 1'b0;
    wake_int_n = 1'b1;
    req = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK({armed, wres, pin_o, pin_oe_n}, 4'b0001)
    rd(wdg_pkg::AUX_ADDR, 8'h00);
    wr(wdg_pkg::AUX_ADDR, 8'hff);
    rd(wdg_pkg::AUX_ADDR, 8'h10);
    wr(KA, 8'h1e);
    wr(KA, 8'h55);
    wr(KA, 8'he1);
    tick(2);
    `CHK(armed, 1'b0)
    rd(KA, 8'h00);
    wr(KA, 8'h1e);
    key();
    tick(1);
    `CHK(armed, 1'b1)
    repeat (2)
    begin
      tick(16300);
      key();
    end
    wr(KA, 8'h00);
    tick(1);
    `CHK(armed, 1'b1)
    key();
    // Power-down is first held with the clock running, so its own gate is exercised.
    @(posedge clk);
    power_down <= 1'b1;
    tick(16390);
    `CHK(armed, 1'b1)
    clk_en <= 1'b0;
    tick(20);
    @(posedge clk);
    wake_int_n <= 1'b0;
    clk_en <= 1'b1;
    tick(4);
    power_down <= 1'b0;
    tick(16390);
    `CHK(armed, 1'b1)
    wake_int_n <= 1'b1;
    key();
    @(posedge clk);
    idle_mode <= 1'b1;
    tick(16390);
    `CHK(armed, 1'b1)
    wr(wdg_pkg::AUX_ADDR, 8'h00);
    key();
    tick(16383);
    `CHK(wres, 1'b0)
    tick(1);
    `CHK({wres, pin_o, pin_oe_n, armed}, 4'b1100)
    tick(wdg_pkg::RST_PULSE_CYC - 1);
    `CHK({wres, pin_oe_n}, 2'b10)
    tick(1);
    `CHK({wres, pin_o, pin_oe_n, armed}, 4'b0010)
    key();
    tick(1);
    `CHK(armed, 1'b1)
    rst_n <= 1'b0;
    tick(2);
    `CHK({armed, wres, pin_o, pin_oe_n}, 4'b0001)
    @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    wr(KA, wdg_pkg::KEY_SECOND);
    tick(1);
    `CHK(armed, 1'b0)
    end_of_test();
  end
endmodule
`default_nettype wire
